// [inc/rhc_pkg.sv]
// rhc_pkg: constants, field layouts and state types for both link ends
// assumes one 25 MHz clock shared by the device end and the host end
package rhc_pkg;

    // ======================================================
    // device register map
    localparam logic [6:0] ADR_IST1 = 7'h03;
    localparam logic [6:0] ADR_IST2 = 7'h04;
    localparam logic [6:0] ADR_IEN1 = 7'h05;
    localparam logic [6:0] ADR_IEN2 = 7'h06;
    localparam logic [6:0] ADR_FC1 = 7'h76;
    localparam logic [6:0] ADR_FC0 = 7'h77;
    localparam logic [6:0] ADR_HOPCH = 7'h79;
    localparam logic [6:0] ADR_HOPSTEP = 7'h7A;
    localparam logic [6:0] ADR_RSV = 7'h7B;
    localparam logic [6:0] ADR_TXAF = 7'h7C;
    localparam logic [6:0] ADR_TXAE = 7'h7D;
    localparam logic [6:0] ADR_RXAF = 7'h7E;
    localparam logic [6:0] ADR_FIFO = 7'h7F;
    localparam logic [15:0] FC_RST = 16'hBB80;
    localparam logic [5:0] TXAF_RST = 6'h37;
    localparam logic [5:0] TXAE_RST = 6'h04;
    localparam logic [5:0] RXAF_RST = 6'h37;
    localparam logic [6:0] FIFO_DEPTH = 7'h40;
    // status 1 bits: 0 tx almost empty, 1 tx almost full, 2 rx almost full
    // status 2 bit 0: queue overflow or underflow

    // ======================================================
    // timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int SCLK_HALF_NS = 500;
    localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0] HALF_LAST = 8'(SCLK_HALF_CYC - 1);

    // ======================================================
    // host register map (byte offsets on the AXI4-Lite side)
    localparam logic [4:0] HOFS_CTRL = 5'h00;
    localparam logic [4:0] HOFS_ADDR = 5'h04;
    localparam logic [4:0] HOFS_WDATA = 5'h08;
    localparam logic [4:0] HOFS_RDATA = 5'h0C;
    localparam logic [4:0] HOFS_STAT = 5'h10;
    localparam logic [4:0] HOFS_IST = 5'h14;
    localparam logic [4:0] HOFS_IMASK = 5'h18;
    localparam logic [4:0] HOFS_PINS = 5'h1C;
    localparam logic [1:0] MODE_TX = 2'h1;
    localparam logic [1:0] MODE_RX = 2'h2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ======================================================
    // state types
    typedef struct packed {
        logic [7:0] hop_ch, hop_step;
        logic [15:0] fc, carrier;
        logic [5:0] txaf, txae, rxaf;
        logic [7:0] ist1, ist2, ien1, ien2;
        logic [2:0] lvl;
        logic recalc, irq_n, sclk_q, addr_ph, rw, sdo, sdo_oe;
        logic [2:0] bitcnt;
        logic [6:0] addr;
        logic [7:0] sh_in, sh_out, tx_head;
        logic [5:0] tx_wp, tx_rp, rx_wp, rx_rp;
        logic [6:0] tx_cnt, rx_cnt;
        logic tx_empty, rx_full, sw_tx, sw_rx;
    } rhc_dev_t;

    localparam rhc_dev_t DEV_RST = '{fc: FC_RST, carrier: FC_RST, txaf: TXAF_RST,
        txae: TXAE_RST, rxaf: RXAF_RST, irq_n: 1'b1, addr_ph: 1'b1, tx_empty: 1'b1,
        default: '0};

    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_LEAD = 3'b001,
        HS_RISE = 3'b010,
        HS_FALL = 3'b011,
        HS_END = 3'b100
    } rhc_hst_t;

    typedef struct packed {
        rhc_hst_t st;
        logic awready, wready, bvalid, arready, rvalid, aw_ok, w_ok;
        logic [1:0] bresp, rresp, len, ist, imask, mode;
        logic [31:0] rdata, wdata, wd, rd;
        logic [4:0] awaddr;
        logic [3:0] wstrb;
        logic wr, pd, irq, irq_q, sclk, mosi, sel_n, tx_n, rx_n;
        logic [6:0] addr;
        logic [7:0] cnt, sh, sh_in;
        logic [2:0] bitcnt, bytecnt;
    } rhc_host_t;

    localparam rhc_host_t HOST_RST = '{st: HS_IDLE, awready: 1'b1, wready: 1'b1,
        arready: 1'b1, sel_n: 1'b1, tx_n: 1'b1, rx_n: 1'b1, irq_q: 1'b1, default: '0};

endpackage

// [inc/rhc_link_if.sv]
// rhc_link_if: the four-wire serial link plus control pins
// assumes both ends are clocked by the same clock
`timescale 1ns/100ps
`default_nettype none
interface rhc_link_if;
    logic sclk, mosi, serial_select_n, miso, miso_oe;
    logic host_interrupt_n, power_down_input, tx_path_sel_n, rx_path_sel_n;
    logic miso_line;

    // released serial output idles high
    assign miso_line = miso_oe ? miso : 1'b1;

    modport dev (input sclk, mosi, serial_select_n, power_down_input,
        tx_path_sel_n, rx_path_sel_n, output miso, miso_oe, host_interrupt_n);
    modport host (output sclk, mosi, serial_select_n, power_down_input,
        tx_path_sel_n, rx_path_sel_n, input miso_line, host_interrupt_n);
endinterface
`default_nettype wire

// [hdl/rhc_device.sv]
// rhc_device: radio control port, serial slave with queues and hop carrier
// assumes link pins synchronous to CLK_I and serial clock idling low
`timescale 1ns/100ps
`default_nettype none
module rhc_device (
    input wire logic CLK_I, // 25 MHz clock
    input wire logic NRST_I, // async reset, low
    rhc_link_if.dev LINK, // serial link to host
    input wire logic TX_POP_I, // modem takes tx head
    output logic [7:0] TX_DATA_O, // tx queue head
    output logic TX_EMPTY_O, // tx queue empty
    input wire logic RX_PUSH_I, // modem stores a byte
    input wire logic [7:0] RX_DATA_I, // byte to store
    output logic RX_FULL_O, // rx queue full
    output logic [15:0] CARRIER_O, // synthesized carrier
    output logic SW_TX_O, // switch set for transmit
    output logic SW_RX_O // switch set for receive
);
    import rhc_pkg::*;

    // ======================================================
    // state
    rhc_dev_t r, n;
    logic [7:0] tx_mem [64];
    logic [7:0] rx_mem [64];
    logic rise, fall, ld, wr, tx_push, tx_pop, rx_push, rx_pop, err, tx_we, rx_we;
    logic [6:0] ld_addr;
    logic [7:0] byte_in, wbyte;
    logic [2:0] lvl_now;

    function automatic logic [6:0] step_addr(input logic [6:0] a);
        // queue port stays put so bursts stream the queue
        step_addr = (a == ADR_FIFO) ? a : a + 7'h01;
    endfunction

    function automatic logic [7:0] reg_rd(input rhc_dev_t s, input logic [6:0] a,
        input logic [7:0] qb);
        case (a)
            ADR_IST1: reg_rd = s.ist1;
            ADR_IST2: reg_rd = s.ist2;
            ADR_IEN1: reg_rd = s.ien1;
            ADR_IEN2: reg_rd = s.ien2;
            ADR_FC1: reg_rd = s.fc[15:8];
            ADR_FC0: reg_rd = s.fc[7:0];
            ADR_HOPCH: reg_rd = s.hop_ch;
            ADR_HOPSTEP: reg_rd = s.hop_step;
            ADR_TXAF: reg_rd = {2'h0, s.txaf};
            ADR_TXAE: reg_rd = {2'h0, s.txae};
            ADR_RXAF: reg_rd = {2'h0, s.rxaf};
            ADR_FIFO: reg_rd = qb;
            default: reg_rd = 8'h00;
        endcase
    endfunction

    // ======================================================
    // next state
    always_comb
    begin
        n = r;
        ld = 1'b0;
        wr = 1'b0;
        ld_addr = r.addr;
        tx_push = 1'b0;
        rx_pop = 1'b0;
        n.recalc = 1'b0;
        n.sclk_q = LINK.sclk;
        rise = LINK.sclk & ~r.sclk_q;
        fall = ~LINK.sclk & r.sclk_q;
        byte_in = {r.sh_in[6:0], LINK.mosi};
        tx_pop = TX_POP_I & (r.tx_cnt != 7'h00);
        rx_push = RX_PUSH_I & (r.rx_cnt != FIFO_DEPTH);
        err = (TX_POP_I & (r.tx_cnt == 7'h00)) | (RX_PUSH_I & (r.rx_cnt == FIFO_DEPTH));

        if (LINK.serial_select_n)
        begin
            n.bitcnt = 3'h0;
            n.addr_ph = 1'b1;
            n.sdo_oe = 1'b0;
            n.sdo = 1'b0;
        end
        else
        begin
            n.sdo_oe = 1'b1;
            if (rise)
            begin
                n.sh_in = byte_in;
                n.bitcnt = r.bitcnt + 3'h1;
                // pop on the first rise of the data byte, once the queued byte is loaded to shift out
                if ((r.bitcnt == 3'h0) && !r.addr_ph && !r.rw && (r.addr == ADR_FIFO))
                begin
                    rx_pop = (r.rx_cnt != 7'h00);
                    err = err | (r.rx_cnt == 7'h00);
                end
                if (r.bitcnt == 3'h7)
                begin
                    if (r.addr_ph)
                    begin
                        n.addr_ph = 1'b0;
                        n.rw = byte_in[7];
                        n.addr = byte_in[6:0];
                        ld = ~byte_in[7];
                        ld_addr = byte_in[6:0];
                    end
                    else if (r.rw)
                    begin
                        wr = 1'b1;
                        n.addr = step_addr(r.addr);
                    end
                    else
                    begin
                        n.addr = step_addr(r.addr);
                        ld = 1'b1;
                        ld_addr = step_addr(r.addr);
                    end
                end
            end
            if (fall)
            begin
                n.sdo = r.sh_out[7];
                n.sh_out = {r.sh_out[6:0], 1'b0};
            end
        end

        // read side effects
        if (ld)
        begin
            n.sh_out = reg_rd(r, ld_addr, rx_mem[r.rx_rp]);
            if (ld_addr == ADR_IST1)
            begin
                n.ist1 = 8'h00;
            end
            if (ld_addr == ADR_IST2)
            begin
                n.ist2 = 8'h00;
            end
        end

        // register writes
        if (wr)
        begin
            case (r.addr)
                ADR_IEN1: n.ien1 = byte_in;
                ADR_IEN2: n.ien2 = byte_in;
                ADR_FC1:
                begin
                    n.fc[15:8] = byte_in;
                    n.recalc = 1'b1;
                end
                ADR_FC0:
                begin
                    n.fc[7:0] = byte_in;
                    n.recalc = 1'b1;
                end
                ADR_HOPCH:
                begin
                    n.hop_ch = byte_in;
                    n.recalc = 1'b1;
                end
                ADR_HOPSTEP:
                begin
                    n.hop_step = byte_in;
                    n.recalc = 1'b1;
                end
                ADR_TXAF: n.txaf = byte_in[5:0];
                ADR_TXAE: n.txae = byte_in[5:0];
                ADR_RXAF: n.rxaf = byte_in[5:0];
                ADR_FIFO:
                begin
                    tx_push = (r.tx_cnt != FIFO_DEPTH);
                    err = err | (r.tx_cnt == FIFO_DEPTH);
                end
                default: n.ien1 = n.ien1;
            endcase
        end

        if (r.recalc)
        begin
            n.carrier = r.fc + ({8'h00, r.hop_ch} * {8'h00, r.hop_step});
        end

        // queues
        tx_we = tx_push;
        rx_we = rx_push;
        wbyte = byte_in;
        if (tx_push)
        begin
            n.tx_wp = r.tx_wp + 6'h01;
        end
        if (tx_pop)
        begin
            n.tx_rp = r.tx_rp + 6'h01;
        end
        if (rx_push)
        begin
            n.rx_wp = r.rx_wp + 6'h01;
        end
        if (rx_pop)
        begin
            n.rx_rp = r.rx_rp + 6'h01;
        end
        n.tx_cnt = r.tx_cnt + {6'h00, tx_push} - {6'h00, tx_pop};
        n.rx_cnt = r.rx_cnt + {6'h00, rx_push} - {6'h00, rx_pop};
        n.tx_empty = (n.tx_cnt == 7'h00);
        n.rx_full = (n.rx_cnt == FIFO_DEPTH);
        n.tx_head = (tx_we && (r.tx_wp == n.tx_rp)) ? wbyte : tx_mem[n.tx_rp];

        // level crossings into status, set wins over clear
        lvl_now = {n.rx_cnt >= {1'b0, n.rxaf}, n.tx_cnt >= {1'b0, n.txaf},
            n.tx_cnt <= {1'b0, n.txae}};
        n.lvl = lvl_now;
        n.ist1 = n.ist1 | {5'h00, lvl_now & ~r.lvl};
        n.ist2 = n.ist2 | {7'h00, err};
        n.irq_n = ~|((n.ist1 & n.ien1) | (n.ist2 & n.ien2));

        n.sw_tx = ~LINK.tx_path_sel_n & LINK.rx_path_sel_n;
        n.sw_rx = ~LINK.rx_path_sel_n & LINK.tx_path_sel_n;

        if (LINK.power_down_input)
        begin
            n = DEV_RST;
            tx_we = 1'b0;
            rx_we = 1'b0;
        end
    end

    // ======================================================
    // registers
    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            r <= DEV_RST;
        end
        else
        begin
            r <= n;
        end
    end

    always_ff @(posedge CLK_I)
    begin
        if (tx_we)
        begin
            tx_mem[r.tx_wp] <= wbyte;
        end
        if (rx_we)
        begin
            rx_mem[r.rx_wp] <= RX_DATA_I;
        end
    end

    // ======================================================
    // outputs
    assign LINK.miso = r.sdo;
    assign LINK.miso_oe = r.sdo_oe;
    assign LINK.host_interrupt_n = r.irq_n;
    assign TX_DATA_O = r.tx_head;
    assign TX_EMPTY_O = r.tx_empty;
    assign RX_FULL_O = r.rx_full;
    assign CARRIER_O = r.carrier;
    assign SW_TX_O = r.sw_tx;
    assign SW_RX_O = r.sw_rx;
endmodule
`default_nettype wire

// [hdl/rhc_host.sv]
// rhc_host: AXI4-Lite controlled master for the radio control port
// assumes the device end shares CLK_I
`timescale 1ns/100ps
`default_nettype none
module rhc_host (
    input wire logic CLK_I, // 25 MHz clock
    input wire logic NRST_I, // async reset, low
    input wire logic [4:0] S_AXI_AWADDR, // write address
    input wire logic S_AXI_AWVALID, // write address valid
    output logic S_AXI_AWREADY, // write address ready
    input wire logic [31:0] S_AXI_WDATA, // write data
    input wire logic [3:0] S_AXI_WSTRB, // byte strobes
    input wire logic S_AXI_WVALID, // write data valid
    output logic S_AXI_WREADY, // write data ready
    output logic [1:0] S_AXI_BRESP, // write response
    output logic S_AXI_BVALID, // response valid
    input wire logic S_AXI_BREADY, // response ready
    input wire logic [4:0] S_AXI_ARADDR, // read address
    input wire logic S_AXI_ARVALID, // read address valid
    output logic S_AXI_ARREADY, // read address ready
    output logic [31:0] S_AXI_RDATA, // read data
    output logic [1:0] S_AXI_RRESP, // read response
    output logic S_AXI_RVALID, // read data valid
    input wire logic S_AXI_RREADY, // read data ready
    rhc_link_if.host LINK, // serial link to device
    output logic IRQ_O // interrupt, high
);
    import rhc_pkg::*;

    // ======================================================
    // state
    rhc_host_t r, n;
    logic tick, done;
    logic [31:0] wv;
    logic [1:0] ev, clr;
    logic [4:0] bsel;
    logic [32:0] wcur, rcur;

    function automatic logic [32:0] host_rd(input rhc_host_t s, input logic [4:0] a,
        input logic irq_n);
        case (a)
            HOFS_CTRL: host_rd = {1'b1, 28'h0, s.len, s.wr, 1'b0};
            HOFS_ADDR: host_rd = {1'b1, 25'h0, s.addr};
            HOFS_WDATA: host_rd = {1'b1, s.wd};
            HOFS_RDATA: host_rd = {1'b1, s.rd};
            HOFS_STAT: host_rd = {1'b1, 30'h0, ~irq_n, s.st != HS_IDLE};
            HOFS_IST: host_rd = {1'b1, 30'h0, s.ist};
            HOFS_IMASK: host_rd = {1'b1, 30'h0, s.imask};
            HOFS_PINS: host_rd = {1'b1, 29'h0, s.mode, s.pd};
            default: host_rd = 33'h0;
        endcase
    endfunction

    // ======================================================
    // next state
    always_comb
    begin
        n = r;
        done = 1'b0;
        clr = 2'h0;
        wv = 32'h0;
        bsel = 5'h0;
        tick = (r.cnt == HALF_LAST);
        wcur = host_rd(r, r.awaddr, LINK.host_interrupt_n);
        rcur = host_rd(r, S_AXI_ARADDR, LINK.host_interrupt_n);

        // bus slave
        if (S_AXI_AWVALID && r.awready)
        begin
            n.awready = 1'b0;
            n.aw_ok = 1'b1;
            n.awaddr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && r.wready)
        begin
            n.wready = 1'b0;
            n.w_ok = 1'b1;
            n.wdata = S_AXI_WDATA;
            n.wstrb = S_AXI_WSTRB;
        end
        if (r.aw_ok && r.w_ok && !r.bvalid)
        begin
            for (int i = 0; i < 4; i++)
            begin
                wv[8 * i +: 8] = r.wstrb[i] ? r.wdata[8 * i +: 8] : wcur[8 * i +: 8];
            end
            n.aw_ok = 1'b0;
            n.w_ok = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = wcur[32] ? RESP_OKAY : RESP_SLVERR;
            case (r.awaddr)
                HOFS_CTRL:
                begin
                    n.wr = wv[1];
                    n.len = wv[3:2];
                end
                HOFS_ADDR: n.addr = wv[6:0];
                HOFS_WDATA: n.wd = wv;
                HOFS_IST: clr = r.wdata[1:0] & {2{r.wstrb[0]}};
                HOFS_IMASK: n.imask = wv[1:0];
                HOFS_PINS:
                begin
                    n.pd = wv[0];
                    n.mode = wv[2:1];
                end
                default: n.wd = n.wd;
            endcase
            if ((r.awaddr == HOFS_CTRL) && wv[0] && (r.st == HS_IDLE) && !r.pd)
            begin
                n.st = HS_LEAD;
                n.sel_n = 1'b0;
                n.cnt = 8'h00;
                n.bitcnt = 3'h0;
                n.bytecnt = 3'h0;
                n.sh = {wv[1], wv[6:0] & 7'h00 | r.addr};
                n.mosi = wv[1];
            end
        end
        if (r.bvalid && S_AXI_BREADY)
        begin
            n.bvalid = 1'b0;
            n.awready = 1'b1;
            n.wready = 1'b1;
        end
        if (S_AXI_ARVALID && r.arready)
        begin
            n.arready = 1'b0;
            n.rvalid = 1'b1;
            n.rdata = rcur[31:0];
            n.rresp = rcur[32] ? RESP_OKAY : RESP_SLVERR;
        end
        if (r.rvalid && S_AXI_RREADY)
        begin
            n.rvalid = 1'b0;
            n.arready = 1'b1;
        end

        // serial engine
        if (r.st != HS_IDLE)
        begin
            n.cnt = tick ? 8'h00 : r.cnt + 8'h01;
        end
        if (tick)
        begin
            case (r.st)
                HS_LEAD: n.st = HS_RISE;
                // device samples mosi at this edge
                HS_RISE:
                begin
                    n.sclk = 1'b1;
                    n.sh_in = {r.sh_in[6:0], LINK.miso_line};
                    n.st = HS_FALL;
                end
                HS_FALL:
                begin
                    n.sclk = 1'b0;
                    n.st = HS_RISE;
                    n.bitcnt = r.bitcnt + 3'h1;
                    n.sh = {r.sh[6:0], 1'b0};
                    n.mosi = r.sh[6];
                    if (r.bitcnt == 3'h7)
                    begin
                        if (r.bytecnt != 3'h0)
                        begin
                            bsel = {r.bytecnt[1:0] - 2'h1, 3'h0};
                            n.rd[bsel +: 8] = r.sh_in;
                        end
                        if (r.bytecnt == {1'b0, r.len} + 3'h1)
                        begin
                            n.st = HS_END;
                        end
                        else
                        begin
                            bsel = {r.bytecnt[1:0], 3'h0};
                            n.sh = r.wd[bsel +: 8];
                            n.mosi = r.wd[bsel + 5'h07];
                            n.bytecnt = r.bytecnt + 3'h1;
                        end
                    end
                end
                HS_END:
                begin
                    n.sel_n = 1'b1;
                    n.mosi = 1'b0;
                    n.st = HS_IDLE;
                    done = 1'b1;
                end
                default: n.st = HS_IDLE;
            endcase
        end

        // device interrupt flagged for status reads
        n.irq_q = LINK.host_interrupt_n;
        ev = {r.irq_q & ~LINK.host_interrupt_n, done};
        n.ist = (r.ist & ~clr) | ev;
        n.irq = |(n.ist & n.imask);

        n.tx_n = (n.mode != MODE_TX);
        n.rx_n = (n.mode != MODE_RX);
    end

    // ======================================================
    // registers
    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            r <= HOST_RST;
        end
        else
        begin
            r <= n;
        end
    end

    // ======================================================
    // outputs
    assign S_AXI_AWREADY = r.awready;
    assign S_AXI_WREADY = r.wready;
    assign S_AXI_BVALID = r.bvalid;
    assign S_AXI_BRESP = r.bresp;
    assign S_AXI_ARREADY = r.arready;
    assign S_AXI_RVALID = r.rvalid;
    assign S_AXI_RDATA = r.rdata;
    assign S_AXI_RRESP = r.rresp;
    assign LINK.sclk = r.sclk;
    assign LINK.mosi = r.mosi;
    assign LINK.serial_select_n = r.sel_n;
    assign LINK.power_down_input = r.pd;
    assign LINK.tx_path_sel_n = r.tx_n;
    assign LINK.rx_path_sel_n = r.rx_n;
    assign IRQ_O = r.irq;
endmodule
`default_nettype wire

// [tb/rhc_link_assertions.sv]
// rhc_link_assertions: timing checks on the serial link
// assumes both link ends share CLK_I
`timescale 1ns/100ps
`default_nettype none
module rhc_link_assertions (
    input wire logic CLK_I, // clock
    input wire logic NRST_I, // reset, low
    input wire logic sclk, // serial clock
    input wire logic mosi, // host data
    input wire logic serial_select_n, // frame select
    input wire logic miso_oe, // device drives
    input wire logic host_interrupt_n, // device irq
    input wire logic power_down_input // shutdown
);
    logic sq;
    logic [7:0] cnt;
    // ==========================
    // cycles at current sclk level
    always_ff @(posedge CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            {sq, cnt} <= '0;
        else
            {sq, cnt} <= {sclk, (sclk != sq) ? 8'h01 : cnt + 8'h01};
    end
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!NRST_I);
    sequence s_lead;
        ##26 $rose(sclk);
    endsequence
    // ==========================
    // checks
    a_sclk_idle: assert property (serial_select_n |-> !sclk)
        else $error("sclk outside frame");
    a_frame_lead: assert property ($fell(serial_select_n) |-> s_lead)
        else $error("bad lead time");
    a_high_len: assert property (sclk != sq && !sclk |-> cnt == 8'h0D)
        else $error("bad sclk high time");
    a_frame_tail: assert property ($rose(serial_select_n) |-> cnt == 8'h0D)
        else $error("bad tail time");
    a_mosi_hold: assert property (sclk |-> $stable(mosi))
        else $error("mosi moved while sclk high");
    a_oe_on: assert property (!serial_select_n [*3] |-> miso_oe)
        else $error("miso not driven");
    a_oe_off: assert property (serial_select_n [*3] |-> !miso_oe)
        else $error("miso driven unselected");
    a_pd_quiet: assert property (power_down_input |=> host_interrupt_n && !miso_oe)
        else $error("device active in shutdown");
endmodule
`default_nettype wire

// [tb/radio_host_control_port_test.sv]
// radio_host_control_port_test: host and device ends joined by the link
// assumes one 25 MHz clock, AXI4-Lite access to the host end
`timescale 1ns/100ps
`default_nettype none
module radio_host_control_port_test;
    import rhc_pkg::*;
    logic clk, rst_n, awv, wv, bry, arv, rry, pop, push, irq, sw_tx, sw_rx, empty;
    logic awr, wrd, bv, arr, rvd;
    logic [4:0] awa, ara;
    logic [31:0] wd, rd, rv;
    logic [7:0] rxd, txd;
    logic [15:0] car;
    int n_fail = 0;
    int n_tests = 0;
    rhc_link_if link();
    rhc_device u_rhc_device (.CLK_I(clk), .NRST_I(rst_n), .LINK(link), .TX_POP_I(pop),
        .TX_DATA_O(txd), .TX_EMPTY_O(empty), .RX_PUSH_I(push), .RX_DATA_I(rxd),
        .RX_FULL_O(), .CARRIER_O(car), .SW_TX_O(sw_tx), .SW_RX_O(sw_rx));
    rhc_host u_rhc_host (.CLK_I(clk), .NRST_I(rst_n), .S_AXI_AWADDR(awa),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(), .S_AXI_BVALID(bv),
        .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rd), .S_AXI_RRESP(), .S_AXI_RVALID(rvd), .S_AXI_RREADY(rry),
        .LINK(link), .IRQ_O(irq));
    rhc_link_assertions u_rhc_link_assertions (.CLK_I(clk), .NRST_I(rst_n),
        .sclk(link.sclk), .mosi(link.mosi), .serial_select_n(link.serial_select_n),
        .miso_oe(link.miso_oe), .host_interrupt_n(link.host_interrupt_n),
        .power_down_input(link.power_down_input));
    // ==========================
    // bus and compare tasks
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e)
        begin
            n_fail++;
            $display("BAD t=%0t seen %h want %h", $time, s, e);
        end
    endtask
    task automatic axw(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        {awa, wd, awv, wv, bry} <= {a, d, 3'b111};
        do
        begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
            if (bv) bry <= 1'b0;
        end while (bv !== 1'b1);
    endtask
    task automatic axr(input logic [4:0] a);
        @(posedge clk);
        {ara, arv, rry} <= {a, 2'b11};
        do
        begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            rv = rd;
        end while (rvd !== 1'b1);
        rry <= 1'b0;
    endtask
    // one link frame, waits for the done interrupt
    task automatic xf(input logic [6:0] a, input logic [1:0] n, input logic [31:0] d,
        input logic w);
        axw(5'h04, {25'h0, a});
        axw(5'h08, d);
        axw(5'h00, {28'h0, n, w, 1'b1});
        while (irq !== 1'b1) @(posedge clk);
        axw(5'h14, 32'h1);
        axr(5'h0C);
    endtask
    // ==========================
    // scenarios
    task automatic t_regs;
        xf(7'h79, 2'h3, 32'h0, 1'b0);
        chk(rv, 32'h3700_0000);
        xf(7'h7D, 2'h1, 32'h0, 1'b0);
        chk(rv & 32'hFFFF, 32'h3704);
        xf(7'h79, 2'h3, 32'hFFAA_0503, 1'b1);
        chk({16'h0, car}, {16'h0, FC_RST + 16'h000F});
        xf(7'h79, 2'h3, 32'h0, 1'b0);
        chk(rv, 32'h3F00_0503);
    endtask
    task automatic t_fifo;
        xf(7'h7F, 2'h2, 32'h0033_2211, 1'b1);
        chk({23'h0, empty, txd}, 32'h0011);
        pop <= 1'b1;
        @(posedge clk);
        pop <= 1'b0;
        repeat (3) @(posedge clk);
        chk({24'h0, txd}, 32'h22);
        {push, rxd} <= {1'b1, 8'hA5};
        @(posedge clk);
        rxd <= 8'h5A;
        @(posedge clk);
        push <= 1'b0;
        xf(7'h7F, 2'h1, 32'h0, 1'b0);
        chk(rv & 32'hFFFF, 32'h5AA5);
    endtask
    task automatic t_irq;
        xf(7'h06, 2'h0, 32'h1, 1'b1);
        xf(7'h7F, 2'h0, 32'h0, 1'b0);
        chk(link.host_interrupt_n, 32'h0);
        axr(5'h14);
        chk(rv, 32'h2);
        chk(irq, 32'h0);
        xf(7'h03, 2'h1, 32'h0, 1'b0);
        chk(rv[8], 32'h1);
        chk(link.host_interrupt_n, 32'h1);
    endtask
    task automatic t_pins;
        for (int m = 1; m < 3; m++)
        begin
            axw(5'h1C, 32'(m << 1));
            repeat (3) @(posedge clk);
            chk({link.tx_path_sel_n, link.rx_path_sel_n, sw_tx, sw_rx}, m == 1 ? 6 : 9);
        end
        axw(5'h1C, 32'h1);
        axw(5'h1C, 32'h0);
        chk({16'h0, car}, {16'h0, FC_RST});
        xf(7'h7C, 2'h0, 32'h0, 1'b0);
        chk(rv & 32'hFF, 32'h37);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ==========================
    // clock, watchdog, main sequence
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial
    begin
        #(40 * 80000);
        n_fail++;
        print_verdict;
    end
    initial
    begin
        {rst_n, awv, wv, bry, arv, rry, pop, push} = '0;
        {awa, ara, wd, rxd} = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        axw(5'h18, 32'h1);
        t_regs;
        t_fifo;
        t_irq;
        t_pins;
        print_verdict;
    end
endmodule
`default_nettype wire
